// *** design/slt_pkg.sv ***
// Constants and types for the serial link self-test block.
// Assumes a 32-bit classic Wishbone slave and a 24-bit pixel stream.
package slt_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] TCNT_OFF = 8'h04;
    localparam logic [7:0] FCNT_OFF = 8'h08;
    localparam logic [7:0] LINK_OFF = 8'h0C;
    localparam logic [7:0] ISTAT_OFF = 8'h10;
    localparam logic [7:0] ICLR_OFF = 8'h14;
    localparam logic [7:0] IEN_OFF = 8'h18;

    // Control fields
    localparam int CTRL_SLEEP_BIT = 0;
    localparam int CTRL_TCLR_BIT = 1;
    localparam int CTRL_FCLR_BIT = 2;

    // Link status fields
    localparam int LINK_LOCK_BIT = 0;
    localparam int LINK_TEST_BIT = 1;
    localparam int LINK_AWAKE_BIT = 2;

    // Interrupt event fields
    localparam int IRQ_W = 3;
    localparam int EV_ENTER_BIT = 0;
    localparam int EV_EXIT_BIT = 1;
    localparam int EV_CRC_BIT = 2;

    // Widths and reset values
    localparam int PIX_W = 24;
    localparam int CNT_W = 8;
    localparam logic [7:0] CNT_RST = 8'h00;
    localparam logic SLEEP_RST = 1'b0;

    // Pixel word with its qualifier
    typedef struct packed {
        logic [PIX_W-1:0] data;
        logic valid;
    } slt_pix_type;

    // Operating state, one-hot
    typedef enum logic [2:0] {
        ST_SLEEP = 3'b001,
        ST_NORMAL = 3'b010,
        ST_TEST = 3'b100
    } slt_state_type;

endpackage : slt_pkg

// *** design/slt_selftest.sv ***
// Serializer-side self test: test-pattern substitution, wake on request,
// back-channel CRC error counting and a Wishbone register file.
// Assumes the back-channel receiver delivers decoded, clock-synchronous
// request level, lock level and one-cycle CRC error pulses.
//
// Summary of operation
// - A test request from the back channel makes the link send the test pattern at full speed.
// - In test mode the pixel inputs are ignored and an all-zero payload goes on to scrambling.
// - A sleeping serializer wakes up when a test request arrives.
// - Back-channel CRC errors are counted only while the back channel is locked, shown in bit 0 at 0x0C.
// - Test-mode CRC errors go into an 8-bit counter that clears on every test entry.
// - Outside test the functional counter counts; the test counter holds its last run.
//
// Design decisions made here: the address map and the Wishbone register port.
`timescale 1ns/1ps

module slt_selftest #(
    parameter int CNT_W = slt_pkg::CNT_W
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Back channel decoded status
    input wire logic bc_test_req_i,
    input wire logic bc_lock_i,
    input wire logic bc_crc_err_i,
    // Parallel pixel input
    input wire slt_pkg::slt_pix_type pix_i,
    // Payload towards scrambler and DC-balance encoder
    output slt_pkg::slt_pix_type tx_o,
    output logic tx_full_speed_o,
    output logic awake_o,
    output logic test_active_o,
    // Interrupt
    output logic irq_o
);

    ////////////////////////////////////////////////////////////////////
    // Declarations

    slt_pkg::slt_state_type state_reg;
    slt_pkg::slt_state_type state_next;
    logic sleep_reg;
    logic [CNT_W-1:0] tcnt_reg;
    logic [CNT_W-1:0] fcnt_reg;
    logic [slt_pkg::IRQ_W-1:0] istat_reg;
    logic [slt_pkg::IRQ_W-1:0] ien_reg;
    logic [slt_pkg::IRQ_W-1:0] events;
    slt_pkg::slt_pix_type tx_reg;
    logic ack_reg;
    logic [31:0] rdat_reg;
    logic wb_req;
    logic wr_hit;
    logic enter_test;
    logic exit_test;
    logic crc_counted;
    logic tclr_wr;
    logic fclr_wr;

    // Byte lane 0 written at a given offset
    function automatic logic lane0_wr(input logic [7:0] off);
        lane0_wr = wr_hit && (wb_adr_i == off) && wb_sel_i[0];
    endfunction : lane0_wr

    // Saturating increment, so a long error burst cannot read as few
    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
        if (&v)
        begin
            sat_inc = v;
        end
        else
        begin
            sat_inc = v + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    endfunction : sat_inc

    ////////////////////////////////////////////////////////////////////
    // Bus decode helpers

    assign wb_req = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wr_hit = wb_req && wb_we_i;
    assign tclr_wr = lane0_wr(slt_pkg::CTRL_OFF) && wb_dat_i[slt_pkg::CTRL_TCLR_BIT];
    assign fclr_wr = lane0_wr(slt_pkg::CTRL_OFF) && wb_dat_i[slt_pkg::CTRL_FCLR_BIT];

    ////////////////////////////////////////////////////////////////////
    // Operating state

    // Next state from the back-channel request level
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            slt_pkg::ST_SLEEP:
            begin
                if (bc_test_req_i)
                begin
                    state_next = slt_pkg::ST_TEST;
                end
                else if (!sleep_reg)
                begin
                    state_next = slt_pkg::ST_NORMAL;
                end
            end
            slt_pkg::ST_NORMAL:
            begin
                if (bc_test_req_i)
                begin
                    state_next = slt_pkg::ST_TEST;
                end
                else if (sleep_reg)
                begin
                    state_next = slt_pkg::ST_SLEEP;
                end
            end
            slt_pkg::ST_TEST:
            begin
                // Test length follows the far-end enable exactly
                if (!bc_test_req_i)
                begin
                    state_next = slt_pkg::ST_NORMAL;
                end
            end
            default:
            begin
                state_next = slt_pkg::ST_NORMAL;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg <= slt_pkg::ST_NORMAL;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign enter_test = (state_reg != slt_pkg::ST_TEST) && (state_next == slt_pkg::ST_TEST);
    assign exit_test = (state_reg == slt_pkg::ST_TEST) && (state_next != slt_pkg::ST_TEST);

    // Software sleep bit; a test request wakes the device and clears it
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sleep_reg <= slt_pkg::SLEEP_RST;
        end
        else if (bc_test_req_i)
        begin
            sleep_reg <= 1'b0;
        end
        else if (lane0_wr(slt_pkg::CTRL_OFF))
        begin
            sleep_reg <= wb_dat_i[slt_pkg::CTRL_SLEEP_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Payload path

    // Zero payload in test, sampled pixels in normal, cleared in sleep; the zeros still
    // pass through the scrambler downstream, so the line is not flat
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tx_reg <= '0;
        end
        else if (state_next == slt_pkg::ST_TEST)
        begin
            tx_reg.data <= '0;
            tx_reg.valid <= 1'b1;
        end
        else if (state_next == slt_pkg::ST_NORMAL)
        begin
            tx_reg <= pix_i;
        end
        else
        begin
            tx_reg <= '0;
        end
    end

    assign tx_o = tx_reg;
    assign tx_full_speed_o = (state_reg == slt_pkg::ST_TEST);
    assign test_active_o = (state_reg == slt_pkg::ST_TEST);
    assign awake_o = (state_reg != slt_pkg::ST_SLEEP);

    ////////////////////////////////////////////////////////////////////
    // CRC error counters

    // Errors only count once the back channel is locked
    assign crc_counted = bc_crc_err_i && bc_lock_i;

    // Test counter: cleared on entry, frozen outside test
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tcnt_reg <= CNT_W'(slt_pkg::CNT_RST);
        end
        else if (enter_test || tclr_wr)
        begin
            tcnt_reg <= '0;
        end
        else if (crc_counted && state_reg == slt_pkg::ST_TEST)
        begin
            tcnt_reg <= sat_inc(tcnt_reg);
        end
    end

    // Functional counter runs whenever not in test
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fcnt_reg <= CNT_W'(slt_pkg::CNT_RST);
        end
        else if (fclr_wr)
        begin
            fcnt_reg <= '0;
        end
        else if (crc_counted && state_reg != slt_pkg::ST_TEST)
        begin
            fcnt_reg <= sat_inc(fcnt_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Interrupts

    always_comb
    begin
        events = '0;
        events[slt_pkg::EV_ENTER_BIT] = enter_test;
        events[slt_pkg::EV_EXIT_BIT] = exit_test;
        events[slt_pkg::EV_CRC_BIT] = crc_counted && state_reg == slt_pkg::ST_TEST;
    end

    // Sticky status; a new event wins over a clear in the same cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            istat_reg <= '0;
        end
        else if (lane0_wr(slt_pkg::ICLR_OFF))
        begin
            istat_reg <= (istat_reg & ~wb_dat_i[slt_pkg::IRQ_W-1:0]) | events;
        end
        else
        begin
            istat_reg <= istat_reg | events;
        end
    end

    // Enable mask
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ien_reg <= '0;
        end
        else if (lane0_wr(slt_pkg::IEN_OFF))
        begin
            ien_reg <= wb_dat_i[slt_pkg::IRQ_W-1:0];
        end
    end

    assign irq_o = |(istat_reg & ien_reg);

    ////////////////////////////////////////////////////////////////////
    // Wishbone slave: answers one cycle after the request

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_reg <= 1'b0;
        end
        else
        begin
            ack_reg <= wb_req;
        end
    end

    // Read mux; unmapped and write-only offsets read as zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rdat_reg <= '0;
        end
        else if (wb_req && !wb_we_i)
        begin
            rdat_reg <= '0;
            if (wb_adr_i == slt_pkg::CTRL_OFF)
            begin
                rdat_reg[slt_pkg::CTRL_SLEEP_BIT] <= sleep_reg;
            end
            else if (wb_adr_i == slt_pkg::TCNT_OFF)
            begin
                rdat_reg[CNT_W-1:0] <= tcnt_reg;
            end
            else if (wb_adr_i == slt_pkg::FCNT_OFF)
            begin
                rdat_reg[CNT_W-1:0] <= fcnt_reg;
            end
            else if (wb_adr_i == slt_pkg::LINK_OFF)
            begin
                rdat_reg[slt_pkg::LINK_LOCK_BIT] <= bc_lock_i;
                rdat_reg[slt_pkg::LINK_TEST_BIT] <= test_active_o;
                rdat_reg[slt_pkg::LINK_AWAKE_BIT] <= awake_o;
            end
            else if (wb_adr_i == slt_pkg::ISTAT_OFF)
            begin
                rdat_reg[slt_pkg::IRQ_W-1:0] <= istat_reg;
            end
            else if (wb_adr_i == slt_pkg::IEN_OFF)
            begin
                rdat_reg[slt_pkg::IRQ_W-1:0] <= ien_reg;
            end
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;

endmodule : slt_selftest

// *** tb/slt_far_end.sv ***
// Far-end deserializer model: test request, back-channel lock, CRC error pulses.
// Assumes it shares the serializer clock; all outputs change after rising edges.
`timescale 1ns/1ps
module slt_far_end (
    // Clock and far-end pins
    input wire logic clk_i,
    input wire logic selftest_enable_pin_i,
    input wire logic lock_i,
    // Back channel towards the serializer, result pin
    output logic bc_test_req_o,
    output logic bc_lock_o,
    output logic bc_crc_err_o,
    output logic result_o
);
    logic err_seen_reg = 1'b0;
    logic low_freq_mode = 1'b0;
    int osc_khz;
    // Oscillator rate used when no pixel clock reaches the far end
    assign osc_khz = low_freq_mode ? 12500 : 33000;
    initial bc_crc_err_o = 1'b0;
    // Request follows the enable pin, so the test lasts exactly that long
    assign bc_test_req_o = selftest_enable_pin_i;
    assign bc_lock_o = lock_i;
    // Result high while clean, low once an error was seen, held after the test
    assign result_o = !err_seen_reg;
    // Error memory is never cleared, not even when a new test begins
    always @(posedge clk_i)
    begin
        if (selftest_enable_pin_i && bc_crc_err_o)
            err_seen_reg <= 1'b1;
    end
    // Back-to-back one-cycle error pulses
    task automatic crc_burst(input int n);
        repeat (n)
        begin
            @(posedge clk_i);
            bc_crc_err_o <= 1'b1;
        end
        @(posedge clk_i);
        bc_crc_err_o <= 1'b0;
    endtask : crc_burst
endmodule : slt_far_end

// *** tb/slt_selftest_properties.sv ***
// Checker for the self-test block, bound to its top module.
// Assumes requests are never made together with a CRC pulse on the exit edge.
`timescale 1ns/1ps
module slt_selftest_checker #(
    parameter int CNT_W = 8
) (
    // Clock, reset and bus
    input wire logic clk_i, input wire logic rst_i,
    input wire logic wb_cyc_i, input wire logic wb_stb_i, input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i, input wire logic [31:0] wb_dat_o, input wire logic wb_ack_o,
    // Back channel and payload
    input wire logic bc_test_req_i, input wire logic bc_lock_i, input wire logic bc_crc_err_i,
    input wire slt_pkg::slt_pix_type pix_i, input wire slt_pkg::slt_pix_type tx_o,
    input wire logic tx_full_speed_o, input wire logic awake_o, input wire logic test_active_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [CNT_W-1:0] tcnt_reg;
    logic rd_ack;
    assign rd_ack = wb_ack_o && !wb_we_i;
    // Shadow test counter: cleared on entry, saturating, locked pulses only
    always_ff @(posedge clk_i)
    begin
        if (rst_i || (bc_test_req_i && !test_active_o))
            tcnt_reg <= '0;
        else if (test_active_o && bc_lock_i && bc_crc_err_i && !(&tcnt_reg))
            tcnt_reg <= tcnt_reg + 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////
    AST_TEST_ENTRY: assert property (bc_test_req_i |=> test_active_o && awake_o)
        else $error("test request did not enter test awake");
    AST_FULL_SPEED: assert property (tx_full_speed_o == test_active_o)
        else $error("full speed differs from test state");
    AST_ZERO_PAYLOAD: assert property (test_active_o |-> tx_o.data == '0 && tx_o.valid)
        else $error("payload not zero in test");
    AST_PIX_RESUME: assert property (test_active_o && !bc_test_req_i |=> tx_o == $past(pix_i))
        else $error("pixels not resumed after test");
    AST_EXIT: assert property (test_active_o && !bc_test_req_i |=> !test_active_o)
        else $error("test not left on request release");
    AST_LINK_READ: assert property (rd_ack && wb_adr_i == slt_pkg::LINK_OFF |->
        wb_dat_o == {29'h0, $past(awake_o), $past(test_active_o), $past(bc_lock_i)})
        else $error("link status read wrong");
    AST_TCNT_READ: assert property (rd_ack && wb_adr_i == slt_pkg::TCNT_OFF |->
        wb_dat_o == 32'($past(tcnt_reg)))
        else $error("test counter read wrong");
    AST_ACK_ONE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single pulse after one cycle");
    COV_ENTRY: cover property ($rose(test_active_o));
    COV_CRC_TEST: cover property (test_active_o && bc_crc_err_i && bc_lock_i);
    COV_EXIT: cover property ($fell(test_active_o));
endmodule : slt_selftest_checker

bind slt_selftest slt_selftest_checker #(.CNT_W(CNT_W)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .bc_test_req_i(bc_test_req_i), .bc_lock_i(bc_lock_i),
    .bc_crc_err_i(bc_crc_err_i), .pix_i(pix_i), .tx_o(tx_o), .tx_full_speed_o(tx_full_speed_o),
    .awake_o(awake_o), .test_active_o(test_active_o));

// *** tb/tb.sv ***
// Self-checking bench: Wishbone reads queue expectations, a monitor compares.
// Assumes the far-end model in slt_far_end.sv; pixels are random every cycle.
`timescale 1ns/1ps
module tb;
    logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic wb_ack_o, bc_test_req_i, bc_lock_i, bc_crc_err_i, tx_full_speed_o, awake_o, test_active_o, irq_o;
    logic en_pin = 1'b0, lock_pin = 1'b0;
    slt_pkg::slt_pix_type pix_i = '0, tx_o;
    logic [31:0] exp_q[$];
    int err_count = 0, checked = 0, cyc = 0, n;
    slt_selftest dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .bc_test_req_i(bc_test_req_i), .bc_lock_i(bc_lock_i),
        .bc_crc_err_i(bc_crc_err_i), .pix_i(pix_i), .tx_o(tx_o), .tx_full_speed_o(tx_full_speed_o),
        .awake_o(awake_o), .test_active_o(test_active_o), .irq_o(irq_o));
    slt_far_end far (.clk_i(clk_i), .selftest_enable_pin_i(en_pin), .lock_i(lock_pin),
        .bc_test_req_o(bc_test_req_i), .bc_lock_o(bc_lock_i), .bc_crc_err_o(bc_crc_err_i), .result_o());
    // 200 MHz clock
    initial
    begin
        forever #2.5 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic finish_test;
        $display("Counts: %0d compared, %0d mismatched", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    // One classic cycle; a read queues its data as the expected value
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        if (!we)
            exp_q.push_back(d);
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb
    // Random pixels, which the test mode must ignore
    always @(posedge clk_i)
        pix_i <= 25'($urandom);
    // Read monitor: oldest expectation against each read answer
    always @(posedge clk_i)
    begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
            check(wb_dat_o, exp_q.pop_front());
    end
    // Hang guard, far above the expected few hundred cycles
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(91650));
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        // Reset values and an unmapped offset
        wb(0, slt_pkg::TCNT_OFF, 32'h0);
        wb(0, slt_pkg::FCNT_OFF, 32'h0);
        wb(0, slt_pkg::LINK_OFF, 32'h4);
        wb(0, slt_pkg::ISTAT_OFF, 32'h0);
        wb(0, 8'h1C, 32'h0);
        $display("Test reset_values done");
        // Pulses before lock are ignored, locked ones count outside test
        far.crc_burst(3);
        lock_pin <= 1'b1;
        n = $urandom_range(2, 6);
        far.crc_burst(n);
        wb(0, slt_pkg::FCNT_OFF, 32'(n));
        $display("Test functional_count done");
        // Test run with saturating counter and interrupt
        wb(1, slt_pkg::IEN_OFF, 32'h7);
        en_pin <= 1'b1;
        repeat (2) @(negedge clk_i);
        check(32'(tx_o), 32'h1);
        check(32'(irq_o), 32'h1);
        far.crc_burst(300);
        wb(0, slt_pkg::TCNT_OFF, 32'hFF);
        wb(0, slt_pkg::FCNT_OFF, 32'(n));
        en_pin <= 1'b0;
        far.crc_burst(2);
        wb(0, slt_pkg::TCNT_OFF, 32'hFF);
        wb(0, slt_pkg::FCNT_OFF, 32'(n + 2));
        wb(0, slt_pkg::ISTAT_OFF, 32'h7);
        wb(1, slt_pkg::ICLR_OFF, 32'h7);
        wb(0, slt_pkg::ISTAT_OFF, 32'h0);
        check(32'(irq_o), 32'h0);
        $display("Test test_run done");
        // Request wakes a sleeping serializer and clears the counter
        wb(1, slt_pkg::CTRL_OFF, 32'h1);
        wb(0, slt_pkg::LINK_OFF, 32'h1);
        en_pin <= 1'b1;
        wb(0, slt_pkg::LINK_OFF, 32'h7);
        wb(0, slt_pkg::TCNT_OFF, 32'h0);
        en_pin <= 1'b0;
        $display("Test wake_and_clear done");
        repeat (4) @(posedge clk_i);
        finish_test();
    end
endmodule : tb
